/* hdl/cgdc_top.sv */
`timescale 1ns/10ps
`include "cgdc_defines.svh"

module cgdc_top #(
	parameter int NUM_GEN = `CGDC_NUM_GEN,
	parameter int NUM_CH  = `CGDC_NUM_CH
) (
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_i,
	input  wire logic                                 user_rst_i,
	input  wire logic                                 hsel_i,
	input  wire logic [31:0]                          haddr_i,
	input  wire logic [1:0]                           htrans_i,
	input  wire logic                                 hwrite_i,
	input  wire logic [2:0]                           hsize_i,
	input  wire logic [31:0]                          hwdata_i,
	input  wire logic                                 hready_i,
	input  wire cgdc_pkg::cgdc_chan_type [NUM_CH-1:0] chan_i,
	input  wire cgdc_pkg::cgdc_sel_type               rtc_gen_i,
	output logic [31:0]                               hrdata_o,
	output logic                                      hreadyout_o,
	output logic                                      hresp_o,
	output cgdc_pkg::cgdc_div_type [NUM_GEN-1:0]      div_o
);
	import cgdc_pkg::*;

	localparam int AW = `CGDC_ADDR_BITS;

	if (NUM_GEN != `CGDC_NUM_GEN || NUM_CH < 1 || NUM_CH > 64) begin : g_bad
		$error("cgdc_top: generator count is fixed and channels must be 1 to 64");
	end

	cgdc_bus_state_type state;
	cgdc_bus_state_type next_state;
	cgdc_aphase_type    aph;
	cgdc_aphase_type    next_aph;
	cgdc_sel_type       sel;
	cgdc_sel_type       next_sel;
	logic [31:0]        rdata;
	logic [31:0]        next_rdata;
	logic               ready;
	logic               next_ready;
	logic               resp;
	logic               next_resp;
	logic [NUM_GEN-1:0] keep_q;
	logic [NUM_GEN-1:0] next_keep_q;
	logic [NUM_GEN-1:0] keep;
	logic [NUM_GEN-1:0] slot_keep;
	logic [NUM_GEN-1:0] slot_wr;
	cgdc_div_type [NUM_GEN-1:0] div;
	logic [31:0]        rd_word;
	logic               take;
	logic               in_div;
	logic               wr_go;
	logic               wr_hit;
	cgdc_sel_type       wsel;
	cgdc_div_type       wdiv;
	logic               wsel_ok;
	logic               lock_on1;

	// A request is taken only on the edge that also ends the previous data phase
	assign take    = hsel_i && htrans_i[1] && hready_i;
	assign in_div  = aph.addr == AW'(`CGDC_DIV_OFFSET);
	assign wsel    = hwdata_i[`CGDC_SEL_MSB:`CGDC_SEL_LSB];
	assign wdiv    = hwdata_i[`CGDC_DIV_MSB:`CGDC_DIV_LSB];
	assign wsel_ok = wsel <= `CGDC_SEL_LAST;
	assign wr_go   = state == BUS_WRITE && aph.write && in_div;
	assign wr_hit  = wr_go && wsel_ok;

	cgdc_lock_eval #(
		.NUM_GEN (NUM_GEN),
		.NUM_CH  (NUM_CH)
	) u_lock (
		.chan_i    (chan_i),
		.rtc_gen_i (rtc_gen_i),
		.keep_o    (keep)
	);

	for (genvar g = 0; g < NUM_GEN; g++) begin : g_slot
		// Generator 0 is never protected from a user reset
		assign slot_keep[g] = (g == 0) ? 1'b0 : keep[g];
		assign slot_wr[g]   = wr_hit && wsel == 4'(g);
		cgdc_div_slot #(
			.WIDTH (cgdc_gen_width(g))
		) u_slot (
			.clk_i      (clk_i),
			.rst_i      (rst_i),
			.user_rst_i (user_rst_i),
			.keep_i     (slot_keep[g]),
			.wr_i       (slot_wr[g]),
			.wdiv_i     (wdiv),
			.div_o      (div[g])
		);
	end

	// Reads pick up the factor of the last selector written; a reserved one reads factor zero
	always_comb begin
		rd_word = `CGDC_REG_RESET;
		if (in_div) begin
			rd_word[`CGDC_SEL_MSB:`CGDC_SEL_LSB] = sel;
			if (sel <= `CGDC_SEL_LAST) begin
				rd_word[`CGDC_DIV_MSB:`CGDC_DIV_LSB] = div[sel[2:0]];
			end
		end else if (aph.addr == AW'(`CGDC_STAT_OFFSET)) begin
			rd_word[NUM_GEN-1:0] = keep_q;
		end
	end

	always_comb begin
		next_state  = state;
		next_aph    = aph;
		next_sel    = sel;
		next_rdata  = rdata;
		next_ready  = ready;
		next_resp   = 1'b0;
		next_keep_q = keep;
		unique case (state)
			BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
				next_state = BUS_IDLE;
				if (take) begin
					// Sub-word writes complete on the bus but store nothing
					next_aph.write = hwrite_i && hsize_i == `CGDC_HSIZE_WORD;
					next_aph.addr  = haddr_i[AW-1:0];
					if (hwrite_i) begin
						next_state = BUS_WRITE;
					end else begin
						next_state = BUS_RD_WAIT;
						next_ready = 1'b0;
					end
				end
			end
			BUS_RD_WAIT: begin
				// One wait state lets a write in the previous data phase land first
				next_rdata = rd_word;
				next_ready = 1'b1;
				next_state = BUS_RD_DONE;
			end
		endcase
		if (wr_go) begin
			next_sel = wsel;
		end
		if (rst_i || user_rst_i) begin
			next_state  = BUS_IDLE;
			next_aph    = '0;
			next_sel    = `CGDC_SEL_RESET;
			next_rdata  = `CGDC_REG_RESET;
			next_ready  = 1'b1;
			next_keep_q = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		state  <= next_state;
		aph    <= next_aph;
		sel    <= next_sel;
		rdata  <= next_rdata;
		ready  <= next_ready;
		resp   <= next_resp;
		keep_q <= next_keep_q;
	end

	assign hrdata_o    = rdata;
	assign hreadyout_o = ready;
	assign hresp_o     = resp;
	assign div_o       = div;

	always_comb begin
		lock_on1 = 1'b0;
		for (int c = 0; c < NUM_CH; c++) begin
			if (chan_i[c].lock && chan_i[c].src == 4'h1) begin
				lock_on1 = 1'b1;
			end
		end
	end

	AST_READ_WAIT: assert property (@(posedge clk_i) disable iff (rst_i || user_rst_i)
		take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read did not answer after exactly one wait state");

	AST_WRITE_NO_WAIT: assert property (@(posedge clk_i) disable iff (rst_i || user_rst_i)
		take && hwrite_i |=> hreadyout_o && !hresp_o)
		else $error("write data phase was stalled or not OKAY");

	AST_RESERVED_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_go && !wsel_ok && !user_rst_i |=> div == $past(div) && sel == $past(wsel))
		else $error("reserved selector changed a factor or was not kept");

	AST_GEN1_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_hit && wsel == 4'h1 && !user_rst_i |=> div[1] == $past(wdiv))
		else $error("generator 1 lost factor bits");

	AST_GEN2_NARROW: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_hit && wsel == 4'h2 && !user_rst_i |=> div[2] == 16'($past(wdiv[4:0])))
		else $error("generator 2 factor not cut to five bits");

	AST_OTHER_BYTE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_hit && wsel != 4'h1 && wsel != 4'h2 && !user_rst_i
		|=> div[$past(wsel[2:0])] == 16'($past(wdiv[7:0])))
		else $error("eight-bit generator factor wrong after write");

	AST_WRITE_ONLY_TARGET: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_hit && wsel != 4'h0 && !user_rst_i |=> $stable(div[0]))
		else $error("write touched a generator it did not select");

	AST_POWER_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i) |-> div == '0 && sel == `CGDC_SEL_RESET && hreadyout_o)
		else $error("power reset left a factor or the selector set");

	AST_USER_GEN0: assert property (@(posedge clk_i) disable iff (rst_i)
		user_rst_i |=> div[0] == `CGDC_DIV_RESET)
		else $error("user reset did not clear generator 0");

	AST_USER_LOCKED: assert property (@(posedge clk_i) disable iff (rst_i)
		user_rst_i && (lock_on1 || rtc_gen_i == 4'h1) |=> $stable(div[1]))
		else $error("locked or real-time generator 1 lost its factor");

	AST_READ_FIELDS: assert property (@(posedge clk_i) disable iff (rst_i || user_rst_i)
		state == BUS_RD_WAIT && in_div |=>
		hrdata_o[3:0] == sel && hrdata_o[7:4] == 4'h0 && hrdata_o[31:24] == 8'h00)
		else $error("division register read has wrong fixed fields");

	AST_READ_AFTER_WRITE: assert property (@(posedge clk_i) disable iff (rst_i || user_rst_i)
		wr_hit && take && !hwrite_i && haddr_i[AW-1:0] == AW'(`CGDC_DIV_OFFSET)
		|=> ##1 hrdata_o[3:0] == $past(wsel, 2))
		else $error("read right after write did not see the new selector");

	// Bus, reset, hold and read-back checks, several on internal state; the factor checks above cover the write path

	AST_POWER_ALL_CLEAR: assert property (@(posedge clk_i)
		rst_i |=> div == '0 && sel == `CGDC_SEL_RESET)
		else $error("factors or selector not cleared while power reset is held");

	AST_POWER_READ_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i) |-> hrdata_o == `CGDC_REG_RESET && !hresp_o && state == BUS_IDLE)
		else $error("bus side not idle with zero read data after power reset");

	AST_USER_SEL_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		user_rst_i |=> sel == `CGDC_SEL_RESET && hreadyout_o && hrdata_o == `CGDC_REG_RESET)
		else $error("user reset left the selector or read data set");

	AST_RESP_OKAY: assert property (@(posedge clk_i) disable iff (rst_i)
		!hresp_o)
		else $error("response was not OKAY");

	AST_READY_LOW_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		!hreadyout_o |-> state == BUS_RD_WAIT)
		else $error("bus stalled outside a read wait state");

	AST_SEL_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_go && !user_rst_i |=> $stable(sel))
		else $error("selector changed without a write");

	AST_DIV_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_hit && !user_rst_i |=> $stable(div))
		else $error("a factor changed without a write that selects it");

	AST_SUBWORD_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
		take && hwrite_i && hsize_i != `CGDC_HSIZE_WORD && !user_rst_i |=> !wr_go)
		else $error("sub-word write reached the register");

	AST_READ_FACTOR: assert property (@(posedge clk_i) disable iff (rst_i || user_rst_i)
		state == BUS_RD_WAIT && in_div && sel <= `CGDC_SEL_LAST
		|=> hrdata_o[`CGDC_DIV_MSB:`CGDC_DIV_LSB] == $past(div[sel[2:0]]))
		else $error("read factor is not that of the selected generator");

	AST_READ_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i || user_rst_i)
		state == BUS_RD_WAIT && in_div && sel > `CGDC_SEL_LAST
		|=> hrdata_o[`CGDC_DIV_MSB:`CGDC_DIV_LSB] == `CGDC_DIV_RESET)
		else $error("reserved selector read a nonzero factor");

	AST_READ_STATUS: assert property (@(posedge clk_i) disable iff (rst_i || user_rst_i)
		state == BUS_RD_WAIT && aph.addr == AW'(`CGDC_STAT_OFFSET) |=> hrdata_o == 32'($past(keep_q)))
		else $error("status read does not show the protected mask");

	AST_READ_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i || user_rst_i)
		state == BUS_RD_WAIT && !in_div && aph.addr != AW'(`CGDC_STAT_OFFSET)
		|=> hrdata_o == `CGDC_REG_RESET)
		else $error("unmapped read returned nonzero data");

	AST_RDATA_STANDS: assert property (@(posedge clk_i) disable iff (rst_i || user_rst_i)
		state != BUS_RD_WAIT |=> $stable(hrdata_o))
		else $error("read data moved outside a read");

	AST_STATUS_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
		!user_rst_i |=> keep_q == $past(keep))
		else $error("protected mask register lags or ignores the lock inputs");

endmodule : cgdc_top

/* include/cgdc_defines.svh */
`ifndef CGDC_DEFINES_SVH
`define CGDC_DEFINES_SVH

`define CGDC_NUM_GEN     8
`define CGDC_NUM_CH      8
`define CGDC_ADDR_BITS   8
`define CGDC_DIV_OFFSET  32'h0000_0008
`define CGDC_STAT_OFFSET 32'h0000_000C
`define CGDC_SEL_LSB     0
`define CGDC_SEL_MSB     3
`define CGDC_DIV_LSB     8
`define CGDC_DIV_MSB     23
`define CGDC_W_GEN1      16
`define CGDC_W_GEN2      5
`define CGDC_W_OTHER     8
`define CGDC_SEL_LAST    4'h7
`define CGDC_SEL_RESET   4'h0
`define CGDC_DIV_RESET   16'h0000
`define CGDC_REG_RESET   32'h0000_0000
`define CGDC_HSIZE_WORD  3'h2

`endif

/* include/cgdc_pkg.sv */
package cgdc_pkg;
`include "cgdc_defines.svh"

	typedef logic [3:0]  cgdc_sel_type;
	typedef logic [15:0] cgdc_div_type;

	typedef struct packed {
		logic         lock;
		cgdc_sel_type src;
	} cgdc_chan_type;

	typedef struct packed {
		logic                        write;
		logic [`CGDC_ADDR_BITS-1:0] addr;
	} cgdc_aphase_type;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_RD_WAIT,
		BUS_RD_DONE
	} cgdc_bus_state_type;

	function automatic int cgdc_gen_width(input int gen);
		if (gen == 1) begin
			return `CGDC_W_GEN1;
		end
		if (gen == 2) begin
			return `CGDC_W_GEN2;
		end
		return `CGDC_W_OTHER;
	endfunction : cgdc_gen_width

endpackage : cgdc_pkg

/* hdl/cgdc_lock_eval.sv */
`timescale 1ns/10ps
`include "cgdc_defines.svh"

module cgdc_lock_eval #(
	parameter int NUM_GEN = `CGDC_NUM_GEN,
	parameter int NUM_CH  = `CGDC_NUM_CH
) (
	input  wire cgdc_pkg::cgdc_chan_type [NUM_CH-1:0] chan_i,
	input  wire cgdc_pkg::cgdc_sel_type               rtc_gen_i,
	output logic [NUM_GEN-1:0]                        keep_o
);
	import cgdc_pkg::*;

	if (NUM_GEN < 1 || NUM_GEN > 16 || NUM_CH < 1) begin : g_bad
		$error("cgdc_lock_eval: unsupported generator or channel count");
	end

	for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
		logic locked;
		always_comb begin
			locked = 1'b0;
			for (int c = 0; c < NUM_CH; c++) begin
				if (chan_i[c].lock && chan_i[c].src == 4'(g)) begin
					locked = 1'b1;
				end
			end
		end
		assign keep_o[g] = locked || (rtc_gen_i == 4'(g));
	end

endmodule : cgdc_lock_eval

/* hdl/cgdc_div_slot.sv */
`timescale 1ns/10ps
`include "cgdc_defines.svh"

module cgdc_div_slot #(
	parameter int WIDTH = `CGDC_W_OTHER
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   user_rst_i,
	input  wire logic                   keep_i,
	input  wire logic                   wr_i,
	input  wire cgdc_pkg::cgdc_div_type wdiv_i,
	output cgdc_pkg::cgdc_div_type      div_o
);
	import cgdc_pkg::*;

	logic [WIDTH-1:0] div;
	logic [WIDTH-1:0] next_div;

	if (WIDTH < 1 || WIDTH > 16) begin : g_bad
		$error("cgdc_div_slot: width must be 1 to 16");
	end

	always_comb begin
		next_div = div;
		if (rst_i) begin
			next_div = WIDTH'(`CGDC_DIV_RESET);
		end else if (user_rst_i) begin
			if (!keep_i) begin
				next_div = WIDTH'(`CGDC_DIV_RESET);
			end
		end else if (wr_i) begin
			next_div = wdiv_i[WIDTH-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		div <= next_div;
	end

	assign div_o = 16'(div);

	AST_SLOT_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		(div_o >> WIDTH) == `CGDC_DIV_RESET)
		else $error("bits above the slot width are not zero");

	AST_SLOT_USER_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		user_rst_i && !keep_i |=> div_o == `CGDC_DIV_RESET)
		else $error("unprotected slot not cleared by user reset");

	AST_SLOT_USER_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
		user_rst_i && keep_i |=> $stable(div_o))
		else $error("protected slot changed on user reset");

endmodule : cgdc_div_slot

/* sim/cgdc_top_bench.sv */
`timescale 1ns/10ps

`define CHECK(what, exp, got) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("wrong value %s expected %h seen %h", what, exp, got); \
	end \
end

module cgdc_top_bench;
	import cgdc_pkg::*;

	localparam logic [31:0]  div_addr     = 32'h0000_0008;
	localparam logic [31:0]  free_addr    = 32'h0000_0010;
	localparam logic [31:0]  stat_addr    = 32'h0000_000C;
	localparam cgdc_div_type mask_tab [8] = '{16'h00FF, 16'hFFFF, 16'h001F, 16'h00FF,
	                                         16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF};

	logic                       clk_i = 1'b0;
	logic                       rst_i;
	logic                       user_rst_i;
	logic                       hsel;
	logic                       hwrite;
	logic [1:0]                 htrans;
	logic [2:0]                 hsize;
	logic [31:0]                haddr;
	logic [31:0]                hwdata;
	logic [31:0]                hrdata;
	logic                       hreadyout;
	logic                       hresp;
	cgdc_chan_type [7:0]        chan;
	cgdc_sel_type               rtc_gen;
	cgdc_div_type [7:0]         div;
	logic                       rdy_n;
	logic [31:0]                rdata_n;
	logic [31:0]                rd;
	int                         errors      = 0;
	int                         comparisons = 0;

	always #50 clk_i = ~clk_i;

	// Outputs only move at rising edges, so a falling-edge copy is the value the next rising edge sees
	always @(negedge clk_i) begin
		rdy_n   <= hreadyout;
		rdata_n <= hrdata;
	end

	cgdc_top cgdc_top_inst (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.user_rst_i  (user_rst_i),
		.hsel_i      (hsel),
		.haddr_i     (haddr),
		.htrans_i    (htrans),
		.hwrite_i    (hwrite),
		.hsize_i     (hsize),
		.hwdata_i    (hwdata),
		.hready_i    (hreadyout),
		.chan_i      (chan),
		.rtc_gen_i   (rtc_gen),
		.hrdata_o    (hrdata),
		.hreadyout_o (hreadyout),
		.hresp_o     (hresp),
		.div_o       (div)
	);

	task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= 1'b1;
		haddr  <= a;
		do @(posedge clk_i); while (rdy_n !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_i); while (rdy_n !== 1'b1);
	endtask : bus_write

	task automatic bus_write_read(input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= 1'b1;
		haddr  <= a;
		do @(posedge clk_i); while (rdy_n !== 1'b1);
		// The read's address phase overlaps the write's data phase
		hwrite <= 1'b0;
		hwdata <= d;
		do @(posedge clk_i); while (rdy_n !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		do @(posedge clk_i); while (rdy_n !== 1'b1);
		q = rdata_n;
	endtask : bus_write_read

	task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= 1'b0;
		haddr  <= a;
		do @(posedge clk_i); while (rdy_n !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		do @(posedge clk_i); while (rdy_n !== 1'b1);
		d = rdata_n;
		`CHECK("response", 1'b0, hresp)
	endtask : bus_read

	task automatic complete_run;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		complete_run();
	end

	initial begin
		rst_i      = 1'b1;
		user_rst_i = 1'b0;
		hsel       = 1'b0;
		htrans     = 2'b00;
		hwrite     = 1'b0;
		hsize      = 3'h2;
		haddr      = 32'h0000_0000;
		hwdata     = 32'h0000_0000;
		chan       = '0;
		rtc_gen    = 4'h0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);

		for (int g = 0; g < 8; g++) begin
			`CHECK("power reset factor", 16'h0000, div[g])
		end
		bus_read(div_addr, rd);
		`CHECK("register reset", 32'h0000_0000, rd)
		for (int g = 0; g < 8; g++) begin
			bus_write_read(div_addr, 32'(g), rd);
			`CHECK("selected reset word", 32'(g), rd)
		end
		$display("test reset values done");

		// All ones in the factor field shows exactly which bits each generator keeps
		for (int g = 0; g < 8; g++) begin
			bus_write(div_addr, {8'h00, 16'hFFFF, 4'h0, 4'(g)});
			bus_read(div_addr, rd);
			`CHECK("width read", {8'h00, mask_tab[g], 4'h0, 4'(g)}, rd)
			`CHECK("width factor", mask_tab[g], div[g])
		end
		// A half-word write completes but must leave selector and factor alone
		hsize <= 3'h1;
		bus_write(div_addr, 32'h0012_3401);
		hsize <= 3'h2;
		bus_read(div_addr, rd);
		`CHECK("half-word write read", 32'h0000_FF07, rd)
		`CHECK("half-word write factor", 16'hFFFF, div[1])
		for (int g = 0; g < 8; g++) begin
			`CHECK("kept factor", mask_tab[g], div[g])
		end
		$display("test widths done");

		bus_write(div_addr, 32'h00AB_CD08);
		bus_read(div_addr, rd);
		`CHECK("reserved read", 32'h0000_0008, rd)
		bus_write(free_addr, 32'h00FF_FF01);
		bus_read(free_addr, rd);
		`CHECK("unmapped read", 32'h0000_0000, rd)
		for (int g = 0; g < 8; g++) begin
			`CHECK("untouched factor", mask_tab[g], div[g])
		end
		$display("test reserved done");

		for (int g = 0; g < 8; g++) begin
			bus_write(div_addr, {16'h0000, 8'(8'h10 + g), 4'h0, 4'(g)});
		end
		rtc_gen    <= 4'h3;
		chan[0]    <= '{lock: 1'b1, src: 4'h5};
		chan[1]    <= '{lock: 1'b0, src: 4'h6};
		chan[2]    <= '{lock: 1'b1, src: 4'h0};
		chan[3]    <= '{lock: 1'b1, src: 4'h1};
		@(posedge clk_i);
		user_rst_i <= 1'b1;
		@(posedge clk_i);
		user_rst_i <= 1'b0;
		@(negedge clk_i);
		`CHECK("user reset gen0", 16'h0000, div[0])
		`CHECK("user reset rtc", 16'h0013, div[3])
		`CHECK("user reset locked", 16'h0015, div[5])
		`CHECK("user reset unlocked", 16'h0000, div[6])
		`CHECK("user reset locked gen1", 16'h0011, div[1])
		for (int g = 2; g < 8; g++) begin
			if (g != 3 && g != 5) begin
				`CHECK("user reset free", 16'h0000, div[g])
			end
		end
		@(posedge clk_i);
		bus_read(stat_addr, rd);
		`CHECK("protected mask", 32'h0000_002B, rd)
		bus_read(div_addr, rd);
		`CHECK("user reset read", 32'h0000_0000, rd)
		$display("test user reset done");

		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		for (int g = 0; g < 8; g++) begin
			`CHECK("power reset all", 16'h0000, div[g])
		end
		@(posedge clk_i);
		bus_read(div_addr, rd);
		`CHECK("power reset read", 32'h0000_0000, rd)
		$display("test power reset done");
		complete_run();
	end

endmodule : cgdc_top_bench
